// ### bench/sjt_ctl.sv
// behavioural scan controller on the far side of the test port
`timescale 1ns/10ps
`default_nettype none
module sjt_ctl
  import sjt_pkg::*;
(
  output logic tck_o,
  output logic tms_o,
  output logic tdi_o,
  input wire logic tdo_i,
  input wire logic tdo_oe_n_i
);
  // tck stands low between frames; tms/tdi idle at pull-up level
  initial begin
    tck_o = 1'b0;
    tms_o = 1'b1;
    tdi_o = 1'b1;
  end
  ////////////////////////////////////////////////////////////////////
  // set before rise, read tdo at rise
  task automatic step(input logic ms, input logic di, output logic so,
                      output logic oe_n);
    tms_o = ms;
    tdi_o = di;
    #31.25;
    so = tdo_i;
    oe_n = tdo_oe_n_i;
    tck_o = 1'b1;
    #62.5;
    tck_o = 1'b0;
    // hold time over, line falls back to its pull-up
    tdi_o = 1'b1;
    #31.25;
  endtask
  task automatic reset_tap();
    logic s;
    logic o;
    repeat (5) step(1'b1, 1'b1, s, o);
    step(1'b0, 1'b1, s, o);
  endtask
  ////////////////////////////////////////////////////////////////////
  // only implemented codes, update or park in pause
  task automatic scan(input logic ir, input logic [BSR_W-1:0] din,
                      input int n, input logic upd,
                      output logic [BSR_W-1:0] dout, output logic bad);
    logic s;
    logic o;
    dout = '0;
    bad = 1'b0;
    step(1'b1, 1'b1, s, o);
    if (ir) begin
      step(1'b1, 1'b1, s, o);
    end
    step(1'b0, 1'b1, s, o);
    step(1'b0, 1'b1, s, o);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], s, o);
      dout[i] = s;
      bad = bad | o;
    end
    step(upd, 1'b1, s, o);
    if (upd) begin
      step(1'b0, 1'b1, s, o);
    end
  endtask
  // pause -> exit2 -> update -> idle
  task automatic resume();
    logic s;
    logic o;
    step(1'b1, 1'b1, s, o);
    step(1'b1, 1'b1, s, o);
    step(1'b0, 1'b1, s, o);
  endtask
endmodule
`default_nettype wire

// ### bench/tb.sv
// self-checking bench of the scan test access port
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin \
  $display("[FAIL] %s exp %0h got %0h", nm, e, g); n_errors++; end end
module tb;
  import sjt_pkg::*;
  localparam logic [BSR_W-1:0] OC = 107'h1 << OCELL_IDX;
  localparam logic [BSR_W-1:0] PAT_A =
    107'h2_d3c3_b4a5_9687_7869_5a4b_3c2d | OC;
  localparam logic [BSR_W-1:0] PAT_B = ~PAT_A;
  localparam logic [BSR_W-1:0] PAT_C = PAT_A & ~OC;
  int n_errors = 0;
  int comparisons = 0;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic bsr_out_ready_i = 1'b0;
  logic [BSR_W-1:0] pin_state_i = PAT_A;
  logic tck, tms, tdi, tdo_o, tdo_oe_n_o, bsr_out_valid_o;
  logic bsr_upd_ready_o, extest_o, output_bus_hiz_o, oe_bad;
  logic [BSR_W-1:0] bsr_out_data_o, dout;
  always #2 clk_i = ~clk_i;
  sjt_tap i_sjt_tap (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1),
    .tck_i(tck), .tms_i(tms), .tdi_i(tdi), .tdo_o(tdo_o),
    .tdo_oe_n_o(tdo_oe_n_o), .pin_state_i(pin_state_i),
    .bsr_out_data_o(bsr_out_data_o), .bsr_out_valid_o(bsr_out_valid_o),
    .bsr_out_ready_i(bsr_out_ready_i), .bsr_upd_ready_o(bsr_upd_ready_o),
    .extest_o(extest_o), .output_bus_hiz_o(output_bus_hiz_o));
  sjt_ctl i_sjt_ctl (.tck_o(tck), .tms_o(tms), .tdi_o(tdi),
    .tdo_i(tdo_o), .tdo_oe_n_i(tdo_oe_n_o));
  ////////////////////////////////////////////////////////////////////
  task automatic test_done();
    if (n_errors == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // one handshake per word; receiver otherwise stalls
  task automatic pop(input logic [BSR_W-1:0] exp);
    @(posedge clk_i);
    #1;
    `CHK("valid", 1'b1, bsr_out_valid_o);
    `CHK("word", exp, bsr_out_data_o);
    bsr_out_ready_i = 1'b1;
    @(posedge clk_i);
    #1;
    bsr_out_ready_i = 1'b0;
  endtask
  task automatic t_reset();
    `CHK("oe_n", 1'b1, tdo_oe_n_o);
    `CHK("extest", 1'b0, extest_o);
    `CHK("hiz", 1'b0, output_bus_hiz_o);
    `CHK("valid0", 1'b0, bsr_out_valid_o);
    `CHK("room0", 1'b1, bsr_upd_ready_o);
  endtask
  task automatic t_ir_cap();
    i_sjt_ctl.reset_tap();
    i_sjt_ctl.scan(1'b1, BSR_W'(INS_BYPASS), IR_W, 1'b1, dout, oe_bad);
    `CHK("ir_cap", IR_CAPTURE, dout[IR_W-1:0]);
    `CHK("oe_sh", 1'b0, oe_bad);
    `CHK("oe_idle", 1'b1, tdo_oe_n_o);
    i_sjt_ctl.scan(1'b0, BSR_W'(8'hb4), 8, 1'b1, dout, oe_bad);
    `CHK("byp0", 1'b0, dout[0]);
    `CHK("byp", 8'h68, dout[7:0]);
  endtask
  task automatic t_idcode();
    i_sjt_ctl.reset_tap();
    i_sjt_ctl.scan(1'b0, '1, ID_W, 1'b1, dout, oe_bad);
    `CHK("id", ID_VALUE, dout[ID_W-1:0]);
    `CHK("id_b0", 1'b1, dout[0]);
  endtask
  // bit 47 is internal, so captures are judged without it
  task automatic t_sample();
    i_sjt_ctl.scan(1'b1, BSR_W'(INS_SAMPLE), IR_W, 1'b1, dout, oe_bad);
    i_sjt_ctl.scan(1'b0, PAT_B, BSR_W, 1'b1, dout, oe_bad);
    `CHK("cap1", PAT_A & ~OC, dout & ~OC);
    `CHK("oe1", 1'b0, oe_bad);
    i_sjt_ctl.scan(1'b0, PAT_A, BSR_W, 1'b1, dout, oe_bad);
    `CHK("cap2", PAT_A & ~OC, dout & ~OC);
    `CHK("full", 1'b0, bsr_upd_ready_o);
    i_sjt_ctl.scan(1'b0, PAT_C, BSR_W, 1'b1, dout, oe_bad);
    `CHK("hiz_s", 1'b0, output_bus_hiz_o);
    pop(PAT_B);
    pop(PAT_A);
    `CHK("empty", 1'b0, bsr_out_valid_o);
  endtask
  task automatic t_extest();
    i_sjt_ctl.scan(1'b1, BSR_W'(INS_EXTEST), IR_W, 1'b0, dout, oe_bad);
    `CHK("ext_early", 1'b0, extest_o);
    i_sjt_ctl.resume();
    `CHK("ext", 1'b1, extest_o);
    i_sjt_ctl.scan(1'b0, PAT_C, BSR_W, 1'b1, dout, oe_bad);
    `CHK("cap_x", PAT_A & ~OC, dout & ~OC);
    `CHK("hiz_c0", 1'b1, output_bus_hiz_o);
    pop(PAT_C);
    i_sjt_ctl.scan(1'b0, PAT_A, BSR_W, 1'b1, dout, oe_bad);
    `CHK("hiz_c1", 1'b0, output_bus_hiz_o);
    pop(PAT_A);
  endtask
  task automatic t_highz();
    i_sjt_ctl.scan(1'b1, BSR_W'(INS_HIGHZ), IR_W, 1'b1, dout, oe_bad);
    `CHK("hiz_z", 1'b1, output_bus_hiz_o);
    `CHK("ext_z", 1'b0, extest_o);
    i_sjt_ctl.scan(1'b0, PAT_B, BSR_W, 1'b1, dout, oe_bad);
    `CHK("bsr_z", PAT_A & ~OC, dout & ~OC);
    pop(PAT_B);
    i_sjt_ctl.reset_tap();
    `CHK("hiz_tlr", 1'b0, output_bus_hiz_o);
    // cell was left at zero; reset must preset it again
    i_sjt_ctl.scan(1'b1, BSR_W'(INS_EXTEST), IR_W, 1'b1, dout, oe_bad);
    `CHK("hiz_pre", 1'b0, output_bus_hiz_o);
  endtask
  ////////////////////////////////////////////////////////////////////
  initial begin
    #300000;
    n_errors++;
    test_done();
  end
  initial begin
    repeat (8) @(posedge clk_i);
    #1;
    rst_i = 1'b0;
    repeat (2) @(posedge clk_i);
    #1;
    t_reset();
    t_ir_cap();
    t_idcode();
    t_sample();
    t_extest();
    t_highz();
    test_done();
  end
endmodule
`default_nettype wire

// ### logic/sjt_buf2.sv
// two-entry buffer for boundary update words
`timescale 1ns/10ps
`default_nettype none
module sjt_buf2
  import sjt_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  sjt_buf_if.fifo bus
);
  logic [BSR_W-1:0] mem [2];
  logic wr_ptr;
  logic rd_ptr;
  logic [1:0] count;
  wire do_wr = bus.wr_valid && bus.wr_ready;
  wire do_rd = bus.rd_valid && bus.rd_ready;
  assign bus.wr_ready = (count != 2'h2);
  assign bus.rd_valid = (count != 2'h0);
  assign bus.rd_data = mem[rd_ptr];
  always_ff @(posedge clk_i) begin
    if (ce_i && do_wr) begin
      mem[wr_ptr] <= bus.wr_data;
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wr_ptr <= 1'h0;
      rd_ptr <= 1'h0;
      count <= 2'h0;
    end else if (ce_i) begin
      if (do_wr) begin
        wr_ptr <= ~wr_ptr;
      end
      if (do_rd) begin
        rd_ptr <= ~rd_ptr;
      end
      count <= count + {1'h0, do_wr} - {1'h0, do_rd};
    end
  end
endmodule
`default_nettype wire

// ### logic/sjt_buf_if.sv
// valid/ready carrier between the scan core and its update buffer
`timescale 1ns/10ps
`default_nettype none
interface sjt_buf_if;
  import sjt_pkg::*;
  logic wr_valid;
  logic wr_ready;
  logic [BSR_W-1:0] wr_data;
  logic rd_valid;
  logic rd_ready;
  logic [BSR_W-1:0] rd_data;
  modport fifo (input wr_valid, input wr_data, input rd_ready,
                output wr_ready, output rd_valid, output rd_data);
  modport user (output wr_valid, output wr_data, output rd_ready,
                input wr_ready, input rd_valid, input rd_data);
endinterface
`default_nettype wire

// ### logic/sjt_pkg.sv
// shared constants and types of the scan test access port
`default_nettype none
package sjt_pkg;
  localparam int BSR_W = 107;
  localparam int OCELL_IDX = 47;
  localparam int IR_W = 3;
  localparam int ID_W = 32;
  localparam int TMS_RESET_RISES = 5;
  // instruction codes
  localparam logic [2:0] INS_EXTEST = 3'h0;
  localparam logic [2:0] INS_IDCODE = 3'h1;
  localparam logic [2:0] INS_HIGHZ = 3'h2;
  localparam logic [2:0] INS_SAMPLE = 3'h4;
  localparam logic [2:0] INS_BYPASS = 3'h7;
  localparam logic [2:0] IR_CAPTURE = 3'h1;
  // identification word fields, values arbitrary
  localparam logic [2:0] ID_REVISION = 3'h0;
  localparam logic [16:0] ID_PART = 17'h00001;
  localparam logic [10:0] ID_VENDOR = 11'h001;
  localparam logic ID_PRESENT = 1'h1;
  localparam logic [31:0] ID_VALUE =
    {ID_REVISION, ID_PART, ID_VENDOR, ID_PRESENT};
  localparam logic OCELL_RESET = 1'h1;
  localparam logic BYPASS_CAPTURE = 1'h0;
  typedef enum logic [15:0] {
    ST_TLR   = 16'h0001,
    ST_RTI   = 16'h0002,
    ST_SELDR = 16'h0004,
    ST_CAPDR = 16'h0008,
    ST_SDR   = 16'h0010,
    ST_EX1DR = 16'h0020,
    ST_PDR   = 16'h0040,
    ST_EX2DR = 16'h0080,
    ST_UPDR  = 16'h0100,
    ST_SELIR = 16'h0200,
    ST_CAPIR = 16'h0400,
    ST_SIR   = 16'h0800,
    ST_EX1IR = 16'h1000,
    ST_PIR   = 16'h2000,
    ST_EX2IR = 16'h4000,
    ST_UPIR  = 16'h8000
  } sjt_state_t;
endpackage
`default_nettype wire

// ### logic/sjt_tap.sv
// boundary scan test access port of the burst memory
`timescale 1ns/10ps
`default_nettype none
module sjt_tap
  import sjt_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic tck_i,
  input wire logic tms_i,
  input wire logic tdi_i,
  output logic tdo_o,
  output logic tdo_oe_n_o,
  input wire logic [BSR_W-1:0] pin_state_i,
  output logic [BSR_W-1:0] bsr_out_data_o,
  output logic bsr_out_valid_o,
  input wire logic bsr_out_ready_i,
  output logic bsr_upd_ready_o,
  output logic extest_o,
  output logic output_bus_hiz_o
);
  ////////////////////////////////////////////////////////////////////////
  // link sampling: tck is just another asynchronous input
  logic tck_s1;
  logic tck_s2;
  logic tck_d;
  logic tms_s1;
  logic tms_s2;
  logic tdi_s1;
  logic tdi_s2;
  logic [BSR_W-1:0] pin_s1;
  logic [BSR_W-1:0] pin_s2;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tck_s1 <= 1'h0;
      tck_s2 <= 1'h0;
      tck_d <= 1'h0;
      tms_s1 <= 1'h1;
      tms_s2 <= 1'h1;
      tdi_s1 <= 1'h1;
      tdi_s2 <= 1'h1;
    end else if (ce_i) begin
      tck_s1 <= tck_i;
      tck_s2 <= tck_s1;
      tck_d <= tck_s2;
      tms_s1 <= tms_i;
      tms_s2 <= tms_s1;
      tdi_s1 <= tdi_i;
      tdi_s2 <= tdi_s1;
    end
  end
  // pin states change far faster than tck; a capture may catch a transition
  always_ff @(posedge clk_i) begin
    if (ce_i) begin
      pin_s1 <= pin_state_i;
      pin_s2 <= pin_s1;
    end
  end
  wire tck_rise = ce_i && tck_s2 && !tck_d;
  wire tck_fall = ce_i && !tck_s2 && tck_d;

  ////////////////////////////////////////////////////////////////////////
  // controller state machine
  sjt_state_t state;
  sjt_state_t next_state;
  always_comb begin
    case (state)
      ST_TLR: next_state = tms_s2 ? ST_TLR : ST_RTI;
      ST_RTI: next_state = tms_s2 ? ST_SELDR : ST_RTI;
      ST_SELDR: next_state = tms_s2 ? ST_SELIR : ST_CAPDR;
      ST_CAPDR: next_state = tms_s2 ? ST_EX1DR : ST_SDR;
      ST_SDR: next_state = tms_s2 ? ST_EX1DR : ST_SDR;
      ST_EX1DR: next_state = tms_s2 ? ST_UPDR : ST_PDR;
      ST_PDR: next_state = tms_s2 ? ST_EX2DR : ST_PDR;
      ST_EX2DR: next_state = tms_s2 ? ST_UPDR : ST_SDR;
      ST_UPDR: next_state = tms_s2 ? ST_SELDR : ST_RTI;
      ST_SELIR: next_state = tms_s2 ? ST_TLR : ST_CAPIR;
      ST_CAPIR: next_state = tms_s2 ? ST_EX1IR : ST_SIR;
      ST_SIR: next_state = tms_s2 ? ST_EX1IR : ST_SIR;
      ST_EX1IR: next_state = tms_s2 ? ST_UPIR : ST_PIR;
      ST_PIR: next_state = tms_s2 ? ST_EX2IR : ST_PIR;
      ST_EX2IR: next_state = tms_s2 ? ST_UPIR : ST_SIR;
      ST_UPIR: next_state = tms_s2 ? ST_SELDR : ST_RTI;
      default: next_state = ST_TLR;
    endcase
  end
  // five tms-high rises reach reset from any state
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= ST_TLR;
    end else if (tck_rise) begin
      state <= next_state;
    end
  end
  wire in_tlr = (state == ST_TLR);
  wire step = tck_rise;

  ////////////////////////////////////////////////////////////////////////
  // instruction register
  logic [IR_W-1:0] ir_sh;
  logic [IR_W-1:0] ir;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ir_sh <= IR_CAPTURE;
    end else if (step && state == ST_CAPIR) begin
      // fixed 01 pattern for path checking
      ir_sh <= IR_CAPTURE;
    end else if (step && state == ST_SIR) begin
      ir_sh <= {tdi_s2, ir_sh[IR_W-1:1]};
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ir <= INS_IDCODE;
    end else if (ce_i && in_tlr) begin
      ir <= INS_IDCODE;
    end else if (step && state == ST_UPIR) begin
      ir <= ir_sh;
    end
  end
  // decode; reserved codes fall back to bypass
  // reserved codes are the controller's to avoid
  wire ins_extest = (ir == INS_EXTEST);
  wire ins_highz = (ir == INS_HIGHZ);
  wire ins_id = (ir == INS_IDCODE);
  wire sel_bsr = ins_extest || ins_highz || (ir == INS_SAMPLE);

  ////////////////////////////////////////////////////////////////////////
  // data registers
  logic [BSR_W-1:0] bsr;
  logic [ID_W-1:0] id_sh;
  logic byp;
  wire cap_dr = step && state == ST_CAPDR;
  wire sh_dr = step && state == ST_SDR;
  // msb from tdi, lsb toward tdo
  always_ff @(posedge clk_i) begin
    if (cap_dr && sel_bsr) begin
      bsr <= pin_s2;
    end else if (sh_dr && sel_bsr) begin
      bsr <= {tdi_s2, bsr[BSR_W-1:1]};
    end
  end
  always_ff @(posedge clk_i) begin
    if (cap_dr && ins_id) begin
      id_sh <= ID_VALUE;
    end else if (sh_dr && ins_id) begin
      id_sh <= {tdi_s2, id_sh[ID_W-1:1]};
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      byp <= BYPASS_CAPTURE;
    end else if (cap_dr && !sel_bsr && !ins_id) begin
      byp <= BYPASS_CAPTURE;
    end else if (sh_dr && !sel_bsr && !ins_id) begin
      byp <= tdi_s2;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // update path: latched parallel outputs through a two-entry buffer
  sjt_buf_if ubuf ();
  wire upd_dr = step && state == ST_UPDR && sel_bsr;
  // shifted pattern goes to the latched outputs at update-dr
  // a word arriving while the buffer is full is refused; watch upd_ready
  assign ubuf.wr_valid = upd_dr;
  assign ubuf.wr_data = bsr;
  assign ubuf.rd_ready = bsr_out_ready_i;
  assign bsr_out_valid_o = ubuf.rd_valid;
  assign bsr_out_data_o = ubuf.rd_data;
  assign bsr_upd_ready_o = ubuf.wr_ready;
  sjt_buf2 u_buf (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .bus(ubuf.fifo)
  );
  logic ocell;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ocell <= OCELL_RESET;
    end else if (ce_i && in_tlr) begin
      ocell <= OCELL_RESET;
    end else if (upd_dr) begin
      ocell <= bsr[OCELL_IDX];
    end
  end
  wire next_hiz = ins_highz || (ins_extest && !ocell);
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      output_bus_hiz_o <= 1'h0;
      extest_o <= 1'h0;
    end else if (ce_i) begin
      output_bus_hiz_o <= next_hiz;
      extest_o <= ins_extest;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // serial output, changed on the tck falling edge only
  // one register on the path
  wire dr_lsb = sel_bsr ? bsr[0] : (ins_id ? id_sh[0] : byp);
  wire next_tdo = (state == ST_SIR) ? ir_sh[0] : dr_lsb;
  wire shifting = (state == ST_SIR) || (state == ST_SDR);
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tdo_o <= 1'h0;
      tdo_oe_n_o <= 1'h1;
    end else if (tck_fall) begin
      tdo_o <= next_tdo;
      tdo_oe_n_o <= !shifting;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  logic [2:0] tms_hi_cnt;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tms_hi_cnt <= 3'h0;
    end else if (tck_rise) begin
      if (!tms_s2) begin
        tms_hi_cnt <= 3'h0;
      end else if (tms_hi_cnt != 3'h7) begin
        tms_hi_cnt <= tms_hi_cnt + 3'h1;
      end
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_tdo_on_fall;
    $changed(tdo_oe_n_o) |-> $past(tck_fall);
  endproperty
  a_tdo_on_fall: assert property (p_tdo_on_fall)
    else $error("tdo enable moved away from a tck fall");
  property p_tms_reset;
    (tms_hi_cnt >= 3'(TMS_RESET_RISES)) |-> state == ST_TLR;
  endproperty
  a_tms_reset: assert property (p_tms_reset)
    else $error("five tms-high rises did not reach reset");
  property p_por;
    $fell(rst_i) |-> state == ST_TLR && tdo_oe_n_o && ir == INS_IDCODE;
  endproperty
  a_por: assert property (@(posedge clk_i) p_por)
    else $error("power-up reset left port active");
  property p_ir_tlr;
    (ce_i && in_tlr) |=> ir == INS_IDCODE && ocell;
  endproperty
  a_ir_tlr: assert property (p_ir_tlr)
    else $error("reset state did not load identify and preset cell");
  property p_capir;
    (step && state == ST_CAPIR) |=> ir_sh[1:0] == 2'h1;
  endproperty
  a_capir: assert property (p_capir)
    else $error("capture-ir pattern wrong");
  property p_bypass_clr;
    (cap_dr && ir == INS_BYPASS) |=> !byp;
  endproperty
  a_bypass_clr: assert property (p_bypass_clr)
    else $error("bypass not cleared on capture");
  property p_bsr_cap;
    (cap_dr && sel_bsr) |=> bsr == $past(pin_s2);
  endproperty
  a_bsr_cap: assert property (p_bsr_cap)
    else $error("boundary capture mismatch");
  property p_tdo_data;
    $changed(tdo_o) |-> $past(tck_fall);
  endproperty
  a_tdo_data: assert property (p_tdo_data)
    else $error("tdo data moved away from a tck fall");
  property p_id_cap;
    (cap_dr && ins_id) |=> id_sh == ID_VALUE;
  endproperty
  a_id_cap: assert property (p_id_cap)
    else $error("identification word not captured");
  property p_byp_path;
    (sh_dr && ir == INS_BYPASS) |=> byp == $past(tdi_s2);
  endproperty
  a_byp_path: assert property (p_byp_path)
    else $error("bypass flop did not take tdi");
  sequence s_ir_load;
    ($past(step) && $past(state) == ST_UPIR) ||
    ($past(ce_i) && $past(in_tlr));
  endsequence
  property p_ir_update;
    $changed(ir) |-> s_ir_load;
  endproperty
  a_ir_update: assert property (p_ir_update)
    else $error("instruction changed outside update-ir");
  property p_highz;
    $past(ins_highz) |-> output_bus_hiz_o;
  endproperty
  a_highz: assert property (p_highz)
    else $error("output bus not floated under high-z sample");
  property p_oe_cell;
    $past(ins_extest) |-> output_bus_hiz_o == !$past(ocell);
  endproperty
  a_oe_cell: assert property (p_oe_cell)
    else $error("output cell does not gate bus under extest");
  property p_tdo_shift;
    $fell(tdo_oe_n_o) |-> $past(shifting);
  endproperty
  a_tdo_shift: assert property (p_tdo_shift)
    else $error("tdo enabled outside a shift state");
endmodule
`default_nettype wire
